// ==== cpc_defs.svh ====
// Constant offsets, field positions and timing figures of the carrier block.
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH
`define CPC_ADDR_CTRL 8'h00
`define CPC_ADDR_DATA 8'h04
`define CPC_ADDR_STATUS 8'h08
`define CPC_BIT_IRQ_EN 12
`define CPC_BIT_DIR 8
`define CPC_BIT_INIT 7
`define CPC_CNT_LSB 9
`define CPC_CNT_MSB 16
`define CPC_BRAKE_COUNT 8'h06
`define CPC_FINAL_COUNT 8'h01
`define CPC_CLK_MHZ 250
`define CPC_COAST_MS 100
`define CPC_INTERPOSER_MS 27
`define CPC_BLANK_MS 30
`define CPC_STALL_MS 50
`endif

// ==== cpc_pkg.sv ====
// Types shared by the carrier position control block.
package cpc_pkg;
  typedef enum logic [2:0] {
    CPC_IDLE, CPC_RELEASE, CPC_HIGH, CPC_BRAKE, CPC_LOW, CPC_COAST, CPC_INIT
  } cpc_state_t;
  typedef struct packed {
    logic drive_right_n;
    logic drive_left_n;
    logic tach_left_select_n;
    logic high_speed_select_n;
    logic high_power_select_n;
    logic hold_coil_on;
    logic interposer_on;
  } cpc_motor_t;
endpackage

// ==== cpc_sync2.sv ====
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module cpc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule // cpc_sync2
`default_nettype wire

// ==== cpc_carrier_ctrl.sv ====
// Carrier position control: Wishbone slave, countdown and motor sequencer.
// How it works
// R01 - An accepted carrier data word loads the move count into the countdown.
// R02 - Moves over six release hold and interposer, then high speed full power.
// R03 - Each photocell notch pulse lowers a nonzero countdown by exactly one; a data word load wins.
// R04 - At count six in high speed, reverse both drives and select low speed.
// R05 - When feedback shows low speed reached, drive forward again at low speed.
// R06 - At count one drop hold coils and go to low power to coast.
// R07 - Moves of two to six run low speed full power, coast at one.
// R08 - Single moves skip hold coils, use low speed, full power, interposer.
// R09 - Right: right drive low, left high; left: the reverse.
// R10 - Both direction drives are never low together.
// R11 - Tach select low for leftward motion, high otherwise.
// R12 - High-speed select is low for high speed, high for low speed.
// R13 - Speed feedback high means slower than selected; sequencing uses it.
// R14 - High-power select low for high current, high for low current.
// R15 - When idle both drives and the power select stay high.
// R16 - A control write with bit 12 sets the carrier enable flag.
// R17 - Interrupt only when enabled, carrier not busy and printer idle.
// R18 - Processor sends the data word as a plain write after the interrupt.
// R19 - Direction comes from bit 8 of the carrier data word.
// R20 - Initialize bit 7 drives low speed to the bumper; count is ignored.
// R21 - Software keeps the absolute position; the block holds only counts.
// R22 - A data word with nonzero count sets busy, removing the interrupt.
// R23 - A compare flag shows count at most six and picks the first speed.
// R24 - Entering low-speed low-power starts 100 ms, then all drive stops.
// R25 - Notch and speed feedback pass two-flop synchronisers first.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"
module cpc_carrier_ctrl
  import cpc_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int COAST_CYCLES = `CPC_COAST_MS * 1000 * `CPC_CLK_MHZ,
  parameter int INTERPOSER_CYCLES = `CPC_INTERPOSER_MS * 1000 * `CPC_CLK_MHZ,
  parameter int BLANK_CYCLES = `CPC_BLANK_MS * 1000 * `CPC_CLK_MHZ,
  parameter int STALL_CYCLES = `CPC_STALL_MS * 1000 * `CPC_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic printer_idle,
  input wire logic notch_pulse,
  input wire logic below_speed_feedback,
  output logic carrier_data_irq,
  output cpc_motor_t motor
);
  logic [1:0] sync_q;
  logic notch_prev_ff;
  logic ack_ff;
  logic [31:0] dat_o_ff;
  logic carrier_enable_ff;
  logic carrier_op_busy_ff;
  logic low_speed_low_power_ff;
  logic dir_left_ff;
  logic single_ff;
  logic [CNT_W-1:0] count_ff;
  logic [31:0] timer_ff;
  cpc_state_t state_ff;
  cpc_motor_t motor_ff;
  cpc_state_t nxt_state;
  logic [31:0] nxt_timer;
  cpc_motor_t nxt_motor;

  // Both asynchronous inputs go through the same synchroniser pair.
  cpc_sync2 #(.WIDTH(2)) u_sync ( // R25
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({below_speed_feedback, notch_pulse}),
    .sync_out(sync_q)
  );

  wire notch_s = sync_q[0];
  wire slow_s = sync_q[1]; // R13
  wire notch_edge = notch_s && !notch_prev_ff;

  // Byte lanes mask the write word before any field is taken from it.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire [31:0] wdata = wb_dat_i & lane_mask(wb_sel_i);
  wire hit_ctrl = (wb_adr_i == `CPC_ADDR_CTRL);
  wire hit_data = (wb_adr_i == `CPC_ADDR_DATA);
  wire hit_status = (wb_adr_i == `CPC_ADDR_STATUS);
  wire ctrl_wr = bus_req && wb_we_i && hit_ctrl;
  wire data_wr = bus_req && wb_we_i && hit_data;
  wire [CNT_W-1:0] word_count = wdata[`CPC_CNT_MSB:`CPC_CNT_LSB];
  wire word_init = wdata[`CPC_BIT_INIT];
  // A data word while a move runs is dropped; software waits for the irq.
  wire data_take = data_wr && !carrier_op_busy_ff && state_ff == CPC_IDLE;
  wire start_move = data_take && !word_init && (word_count != '0);
  wire start_init = data_take && word_init;

  wire count_le_six = (count_ff <= `CPC_BRAKE_COUNT); // R23
  wire count_final = single_ff ? (count_ff == '0) : // R08
                                 (count_ff <= `CPC_FINAL_COUNT); // R06 R07
  wire timer_done = (timer_ff == 32'h0);

  wire [31:0] status_word = {
    9'h000, motor_ff, count_ff, 2'h0, low_speed_low_power_ff,
    count_le_six, printer_idle, carrier_data_irq, carrier_op_busy_ff,
    carrier_enable_ff
  };
  wire [31:0] read_word = hit_status ? status_word : 32'h0;

  // Wishbone classic: every access, mapped or not, is acked one cycle on.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      dat_o_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_o_ff <= read_word;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_o_ff;

  // The enable flag follows bit 12 of each control word that enables byte lane 1.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      carrier_enable_ff <= 1'b0;
    end else if (ctrl_wr && wb_sel_i[1]) begin
      carrier_enable_ff <= wdata[`CPC_BIT_IRQ_EN]; // R16
    end
  end

  assign carrier_data_irq = carrier_enable_ff && !carrier_op_busy_ff &&
                            printer_idle; // R17

  // Busy is set by a new move and cleared only when the sequence ends.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      carrier_op_busy_ff <= 1'b0;
    end else if (start_move || start_init) begin
      carrier_op_busy_ff <= 1'b1; // R22
    end else if (state_ff != CPC_IDLE && nxt_state == CPC_IDLE) begin
      carrier_op_busy_ff <= 1'b0;
    end
  end

  // Only relative counts are held; the absolute position lives in software.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= '0;
      dir_left_ff <= 1'b0;
      single_ff <= 1'b0;
      notch_prev_ff <= 1'b0;
    end else begin
      notch_prev_ff <= notch_s;
      if (data_take) begin
        dir_left_ff <= wdata[`CPC_BIT_DIR]; // R19
        count_ff <= word_init ? '0 : word_count; // R01 R20
        single_ff <= !word_init && (word_count == CNT_W'(1));
      end else if (notch_edge && count_ff != '0) begin
        count_ff <= count_ff - CNT_W'(1); // R03
      end
    end
  end

  // Sequencer: one shared down-counter times the release, brake, coast and init phases.
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_done ? 32'h0 : timer_ff - 32'h1;
    case (state_ff)
      CPC_IDLE: begin
        if (start_init) begin
          nxt_state = CPC_INIT; // R20
          nxt_timer = 32'(STALL_CYCLES);
        end else if (start_move) begin
          nxt_state = CPC_RELEASE; // R02
          nxt_timer = 32'(INTERPOSER_CYCLES);
        end
      end
      CPC_RELEASE: begin
        if (timer_done) begin
          nxt_state = count_le_six ? CPC_LOW : CPC_HIGH; // R02 R07 R23
        end
      end
      CPC_HIGH: begin
        if (count_le_six) begin
          nxt_state = CPC_BRAKE; // R04
          nxt_timer = 32'(BLANK_CYCLES);
        end
      end
      CPC_BRAKE: begin
        // Feedback is ignored while the blanking time masks switching noise.
        if (timer_done && slow_s) begin
          nxt_state = CPC_LOW; // R05 R13
        end
      end
      CPC_LOW: begin
        if (count_final) begin
          nxt_state = CPC_COAST; // R06
          nxt_timer = 32'(COAST_CYCLES); // R24
        end
      end
      CPC_COAST: begin
        if (timer_done) begin
          nxt_state = CPC_IDLE; // R24
        end
      end
      CPC_INIT: begin
        // A stall is seen as no notch for the whole stall time.
        if (notch_edge) begin
          nxt_timer = 32'(STALL_CYCLES);
        end else if (timer_done) begin
          nxt_state = CPC_IDLE;
        end
      end
      default: begin
        nxt_state = CPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CPC_IDLE;
      timer_ff <= 32'h0;
      low_speed_low_power_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      low_speed_low_power_ff <= (nxt_state == CPC_COAST);
    end
  end

  // Output decode from the present state; registered one cycle later.
  wire drv_fwd = state_ff == CPC_HIGH || state_ff == CPC_LOW ||
                 state_ff == CPC_COAST || state_ff == CPC_INIT;
  wire drv_rev = state_ff == CPC_BRAKE;
  wire go_left = (drv_fwd && dir_left_ff) || (drv_rev && !dir_left_ff);
  wire go_right = (drv_fwd && !dir_left_ff) || (drv_rev && dir_left_ff);
  wire moving = drv_fwd || drv_rev;
  wire full_power = state_ff == CPC_HIGH || state_ff == CPC_BRAKE ||
                    state_ff == CPC_LOW || state_ff == CPC_INIT;

  always_comb begin
    nxt_motor.drive_right_n = !(go_right && !go_left); // R09 R10 R15
    nxt_motor.drive_left_n = !(go_left && !go_right); // R09 R10 R15
    nxt_motor.tach_left_select_n = !(moving && dir_left_ff); // R11
    nxt_motor.high_speed_select_n = !(state_ff == CPC_HIGH); // R04 R12
    nxt_motor.high_power_select_n = !full_power; // R06 R14 R15
    nxt_motor.hold_coil_on = !single_ff && (state_ff == CPC_RELEASE ||
      state_ff == CPC_HIGH || state_ff == CPC_BRAKE ||
      state_ff == CPC_LOW); // R06 R08
    nxt_motor.interposer_on = state_ff == CPC_RELEASE ||
      (single_ff && state_ff == CPC_LOW); // R02 R08
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      motor_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      motor_ff <= nxt_motor;
    end
  end

  assign motor = motor_ff;

  property p_no_dual_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      !(!motor.drive_right_n && !motor.drive_left_n);
  endproperty
  a_no_dual_drive: assert property (p_no_dual_drive) // R10
    else $error("Both direction drives are low together.");

  property p_idle_outputs;
    @(posedge clk_sys) disable iff (!reset_n)
      (state_ff == CPC_IDLE) [*2] |-> motor.drive_right_n &&
        motor.drive_left_n && motor.high_power_select_n;
  endproperty
  a_idle_outputs: assert property (p_idle_outputs) // R15
    else $error("Idle carrier still drives or requests high power.");

  property p_notch_count;
    @(posedge clk_sys) disable iff (!reset_n)
      notch_edge && !data_take && count_ff != '0 |=>
        count_ff == $past(count_ff) - CNT_W'(1);
  endproperty
  a_notch_count: assert property (p_notch_count) // R03
    else $error("Notch did not lower the count by one.");

  property p_busy_set;
    @(posedge clk_sys) disable iff (!reset_n)
      start_move |=> carrier_op_busy_ff && !carrier_data_irq;
  endproperty
  a_busy_set: assert property (p_busy_set) // R22
    else $error("Accepted move did not set busy.");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      carrier_data_irq |-> $past(carrier_enable_ff) || $past(ctrl_wr);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R17
    else $error("Interrupt raised without enable.");

  property p_brake;
    @(posedge clk_sys) disable iff (!reset_n)
      state_ff == CPC_HIGH && count_le_six |-> ##2
        motor.high_speed_select_n &&
        (motor.drive_left_n == dir_left_ff);
  endproperty
  a_brake: assert property (p_brake) // R04
    else $error("Braking did not reverse drive at low speed.");

  property p_coast_power;
    @(posedge clk_sys) disable iff (!reset_n)
      state_ff == CPC_COAST |=> motor.high_power_select_n &&
        !motor.hold_coil_on;
  endproperty
  a_coast_power: assert property (p_coast_power) // R06
    else $error("Coast phase keeps full power or hold coils.");

  property p_enable_set;
    @(posedge clk_sys) disable iff (!reset_n)
      ctrl_wr && wb_sel_i[1] && wdata[`CPC_BIT_IRQ_EN] |=> carrier_enable_ff;
  endproperty
  a_enable_set: assert property (p_enable_set) // R16
    else $error("Control word did not set the enable flag.");

  property p_first_speed;
    @(posedge clk_sys) disable iff (!reset_n)
      state_ff == CPC_RELEASE && timer_done |=>
        (state_ff == CPC_HIGH) == ($past(count_ff) > `CPC_BRAKE_COUNT);
  endproperty
  a_first_speed: assert property (p_first_speed) // R23
    else $error("Initial speed does not follow the count compare.");

  property p_coast_end;
    @(posedge clk_sys) disable iff (!reset_n)
      state_ff == CPC_COAST && timer_done |=> state_ff == CPC_IDLE;
  endproperty
  a_coast_end: assert property (p_coast_end) // R24
    else $error("Coast timer expiry did not end the move.");

  property p_speed_sel;
    @(posedge clk_sys) disable iff (!reset_n)
      !motor.high_speed_select_n |-> $past(state_ff) == CPC_HIGH;
  endproperty
  a_speed_sel: assert property (p_speed_sel) // R12
    else $error("High speed requested outside the high speed phase.");
endmodule // cpc_carrier_ctrl
`default_nettype wire

// ==== cpc_motor_model.sv ====
// Behavioural carrier motor, photocell disk and speed comparator.
`timescale 1ns/1ps
`default_nettype none
module cpc_motor_model
  import cpc_pkg::*;
#(
  parameter int NOTCH_HALF = 6,
  parameter int SLOW_CYCLES = 10
) (
  input wire logic clk_sys,
  input wire cpc_motor_t motor,
  input wire logic at_bumper,
  output logic notch_pulse,
  output logic below_speed_feedback
);
  int ph;
  int slow;
  // Both drives low clamps every driver off, so the disk stands still.
  wire logic moving = (motor.drive_right_n ^ motor.drive_left_n) &&
                      !at_bumper;
  initial begin
    notch_pulse = 1'b0;
    below_speed_feedback = 1'b0;
    ph = 0;
    slow = 0;
  end
  // The low speed is only reached some time after it is selected.
  always @(posedge clk_sys) begin
    ph <= moving ? (ph + 1) % (2 * NOTCH_HALF) : 0;
    notch_pulse <= moving && (ph >= NOTCH_HALF);
    slow <= motor.high_speed_select_n ? slow + 1 : 0;
    below_speed_feedback <= motor.high_speed_select_n && slow >= SLOW_CYCLES;
  end
endmodule // cpc_motor_model
`default_nettype wire

// ==== cpc_carrier_ctrl_test.sv ====
// Self-checking bench for the carrier position control block.
`timescale 1ns/1ps
`default_nettype none
module cpc_carrier_ctrl_test
  import cpc_pkg::*;
;
  localparam int COAST = 20;
  logic clk_sys;
  logic reset_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic printer_idle;
  logic notch_pulse;
  logic below_speed_feedback;
  logic carrier_data_irq;
  logic at_bumper;
  cpc_motor_t motor;
  logic [31:0] rd;
  int bad_count;
  int checks;

  cpc_carrier_ctrl #(
    .COAST_CYCLES(COAST),
    .INTERPOSER_CYCLES(8),
    .BLANK_CYCLES(6),
    .STALL_CYCLES(30)
  ) cpc_carrier_ctrl_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .printer_idle(printer_idle),
    .notch_pulse(notch_pulse),
    .below_speed_feedback(below_speed_feedback),
    .carrier_data_irq(carrier_data_irq),
    .motor(motor)
  );

  cpc_motor_model cpc_motor_model_i (
    .clk_sys(clk_sys),
    .motor(motor),
    .at_bumper(at_bumper),
    .notch_pulse(notch_pulse),
    .below_speed_feedback(below_speed_feedback)
  );

  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic timeout;
    check(32'h1, 32'h0);
    print_verdict;
  endtask

  function automatic logic [31:0] dword(input logic [7:0] cnt,
                                        input logic left, input logic init);
    return {15'h0, cnt, left, init, 7'h0};
  endfunction

  // Every request starts just after a rising edge and holds until ack.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_bit(input int idx, input logic val);
    int n;
    n = 0;
    while (motor[idx] !== val) begin
      @(posedge clk_sys);
      n++;
      if (n > 3000) timeout();
    end
  endtask

  task automatic t_reset;
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h007C0018);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    check({31'h0, carrier_data_irq}, 32'h0);
  endtask

  task automatic t_enable;
    wb(1'b1, 8'h00, 32'h00001000);
    check({31'h0, carrier_data_irq}, 32'h1);
    printer_idle <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({31'h0, carrier_data_irq}, 32'h0);
    printer_idle <= 1'b1;
    wb(1'b1, 8'h00, 32'h0);
    check({31'h0, carrier_data_irq}, 32'h0);
    // With the lane of bit 12 masked off the enable bit must not land.
    wb_sel_i <= 4'hD;
    wb(1'b1, 8'h00, 32'h00001000);
    wb_sel_i <= 4'hF;
    check({31'h0, carrier_data_irq}, 32'h0);
    wb(1'b1, 8'h00, 32'h00001000);
    wb(1'b0, 8'h08, 32'h0);
    check({29'h0, rd[2:0]}, 32'h5);
  endtask

  task automatic t_single;
    int n;
    check({31'h0, carrier_data_irq}, 32'h1);
    wb(1'b1, 8'h04, dword(8'h01, 1'b0, 1'b0));
    check({31'h0, carrier_data_irq}, 32'h0);
    wait_bit(6, 1'b0);
    check({25'h0, motor}, 32'h39);
    wait_bit(2, 1'b1);
    n = 0;
    while (motor !== 7'h7C && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, n >= COAST - 2 && n <= COAST + 2}, 32'h1);
    check({31'h0, carrier_data_irq}, 32'h1);
  endtask

  task automatic t_long;
    wb(1'b1, 8'h04, dword(8'h14, 1'b1, 1'b0));
    wait_bit(3, 1'b0);
    check({27'h0, motor[6:2]}, 32'h10);
    wait_bit(3, 1'b1);
    check({30'h0, motor[6:5]}, 32'h1);
    // A data word during a move is acked but must leave the count alone.
    wb(1'b1, 8'h04, dword(8'h02, 1'b0, 1'b0));
    wb(1'b0, 8'h08, 32'h0);
    check({23'h0, rd[15:8], rd[4]}, 32'h0D);
    wait_bit(5, 1'b0);
    check({27'h0, motor[6:2]}, 32'h12);
    wait_bit(2, 1'b1);
    check({30'h0, motor[1], motor[5]}, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    check({23'h0, rd[15:8], rd[5]}, 32'h3);
    wait_bit(5, 1'b1);
  endtask

  task automatic t_short;
    wb(1'b1, 8'h04, dword(8'h04, 1'b0, 1'b0));
    wait_bit(6, 1'b0);
    check({27'h0, motor[6:2]}, 32'h0E);
    wait_bit(2, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    check({24'h0, rd[15:8]}, 32'h1);
    wait_bit(6, 1'b1);
  endtask

  // The bumper stops the disk, so the stall timer ends the move.
  task automatic t_init;
    at_bumper <= 1'b1;
    wb(1'b1, 8'h04, dword(8'hFF, 1'b1, 1'b1));
    wait_bit(5, 1'b0);
    check({27'h0, motor[6:2]}, 32'h12);
    wait_bit(5, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    check({30'h0, rd[2:1]}, 32'h2);
    at_bumper <= 1'b0;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    printer_idle = 1'b1;
    at_bumper = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_enable();
    t_single();
    t_long();
    t_short();
    t_init();
    print_verdict();
  end
endmodule // cpc_carrier_ctrl_test
`default_nettype wire
